// ===== gpp_port.sv
/*
  Eight-pin general-purpose port: direction, pad gating, pin lock, ADC and DMA
  triggers, nine interrupt sources with raw and masked status.
  Assumes a plain register port, read data one cycle after the read strobe.
*/
// Implementation choices: the register addresses and the strobed register port.
// How it works
// - Each pin has its own input or output direction bit.
// - A peripheral bit hands pin direction and value to the peripheral.
// - Eight-bit vectors, bit n is pin n; write only selected pins.
// - Direction mode per pin reads back with the written encoding.
// - Pad enable must also be set before any signal passes.
// - Protected pins ignore direction, peripheral, pad and select writes until lock key and commit allow.
// - Per-pin ADC trigger enable; cleared bit withdraws that pin.
// - Per-pin DMA trigger enable; cleared bit stops its requests.
// - Trigger use never suppresses the pin's interrupt.
// - Nine sources: eight pins plus DMA activity, each with status.
// - Only enabled sources reach the interrupt output.
// - Writing a one-per-source mask clears chosen pending sources.
// - Peripheral select picks which of two peripheral signals drives a pin.
// - Detection is falling, rising, both edges, low or high level.
// - Status reads as raw or as masked by enables.
// - Reset: inputs, pads disabled, GPIO function.
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
(
  input  wire logic        ref_clk,   // Port clock, 100 MHz
  input  wire logic        srst,      // Sync reset, active high
  input  wire logic [7:0]  reg_addr,  // Register byte address
  input  wire logic [31:0] reg_wdata, // Write data
  input  wire logic        reg_wr,    // Write strobe
  input  wire logic        reg_rd,    // Read strobe
  output logic      [31:0] reg_rdata, // Read data, cycle after strobe
  input  wire logic [7:0]  pin_i,     // Pad input levels
  output logic      [7:0]  pin_o,     // Pad output values
  output logic      [7:0]  pin_oe,    // Pad output enables
  input  wire logic [7:0]  peri_a_o,  // Peripheral A output value
  input  wire logic [7:0]  peri_a_oe, // Peripheral A output enable
  input  wire logic [7:0]  peri_b_o,  // Peripheral B output value
  input  wire logic [7:0]  peri_b_oe, // Peripheral B output enable
  output logic      [7:0]  peri_in,   // Gated pin levels to peripherals
  input  wire logic        dma_done,  // DMA activity pulse
  output logic             adc_trig,  // ADC sequence trigger
  output logic             dma_req,   // DMA transfer request
  output logic             irq        // Port interrupt, level
);

  typedef struct packed {
    logic [7:0]  dir_out;
    logic [7:0]  dir_peri;
    logic [7:0]  pad_en;
    logic [7:0]  data_out;
    logic [7:0]  it_edge;
    logic [7:0]  it_both;
    logic [7:0]  it_pol;
    logic [8:0]  int_en;
    logic [8:0]  int_raw;
    logic [7:0]  adc_en;
    logic [7:0]  dma_en;
    logic [7:0]  psel;
    logic        unlocked;
    logic [7:0]  commit;
    logic [2:0]  dm_pin;
    logic [31:0] rdata;
    logic        adc_trig;
    logic        dma_req;
  } gpp_port_s;

  gpp_port_s st;
  gpp_port_s next_st;

  logic [7:0] in_gated;
  logic [7:0] lvl;
  logic [7:0] hit;
  logic [7:0] can_cfg;
  logic [7:0] wsel;
  logic [7:0] wval;
  logic [8:0] set_src;
  logic [8:0] clr_src;
  logic [8:0] masked;
  gpp_dir_e   dm_code;

  // Pad must be enabled for the pin to reach the detector
  assign in_gated = pin_i & st.pad_en;
  assign peri_in  = lvl;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      gpp_detect u_det (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .pin_in    (in_gated[gi]),
        .edge_mode (st.it_edge[gi]),
        .both_mode (st.it_both[gi]),
        .polarity  (st.it_pol[gi]),
        .level     (lvl[gi]),
        .event_hit (hit[gi])
      );

      always_comb
      begin
        if (!st.pad_en[gi])
        begin
          pin_o[gi]  = 1'b0;
          pin_oe[gi] = 1'b0;
        end
        else if (st.dir_peri[gi])
        begin
          // Peripheral owns direction and value
          pin_o[gi]  = st.psel[gi] ? peri_b_o[gi] : peri_a_o[gi];
          pin_oe[gi] = st.psel[gi] ? peri_b_oe[gi] : peri_a_oe[gi];
        end
        else
        begin
          pin_o[gi]  = st.data_out[gi];
          pin_oe[gi] = st.dir_out[gi];
        end
      end
    end
  endgenerate

  // Locked pins reject config until unlocked and committed
  assign can_cfg = ~PROT_PINS | (st.unlocked ? st.commit : 8'h00);

  assign wsel    = reg_wdata[15:8];
  assign wval    = reg_wdata[7:0];
  assign set_src = {dma_done, hit};
  assign clr_src = (reg_wr && reg_addr == OFS_INT_CLR) ? reg_wdata[8:0] : 9'h000;
  assign masked  = st.int_raw & st.int_en;

  always_comb
  begin
    if (st.dir_peri[st.dm_pin])
      dm_code = GPP_DIR_PERI;
    else if (st.dir_out[st.dm_pin])
      dm_code = GPP_DIR_OUT;
    else
      dm_code = GPP_DIR_IN;
  end

  always_comb
  begin
    next_st = st;
    // Set wins over a clear in the same cycle
    next_st.int_raw  = (st.int_raw & ~clr_src) | set_src;
    next_st.adc_trig = |(hit & st.adc_en);
    next_st.dma_req  = |(hit & st.dma_en);
    next_st.rdata    = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        // Config vectors: low byte values, next byte pin selects
        OFS_DIR_OUT:
          next_st.dir_out = (st.dir_out & ~(wsel & can_cfg)) | (wval & wsel & can_cfg);
        OFS_DIR_PERI:
          next_st.dir_peri = (st.dir_peri & ~(wsel & can_cfg)) | (wval & wsel & can_cfg);
        OFS_PAD_EN:
          next_st.pad_en = (st.pad_en & ~(wsel & can_cfg)) | (wval & wsel & can_cfg);
        OFS_PSEL:
          next_st.psel = (st.psel & ~(wsel & can_cfg)) | (wval & wsel & can_cfg);
        OFS_DATA_OUT:
          next_st.data_out = (st.data_out & ~wsel) | (wval & wsel);
        OFS_IT_EDGE:
          next_st.it_edge = (st.it_edge & ~wsel) | (wval & wsel);
        OFS_IT_BOTH:
          next_st.it_both = (st.it_both & ~wsel) | (wval & wsel);
        OFS_IT_POL:
          next_st.it_pol = (st.it_pol & ~wsel) | (wval & wsel);
        OFS_ADC_TRG:
          next_st.adc_en = (st.adc_en & ~wsel) | (wval & wsel);
        OFS_DMA_TRG:
          next_st.dma_en = (st.dma_en & ~wsel) | (wval & wsel);
        OFS_INT_EN:
          next_st.int_en = reg_wdata[8:0];
        OFS_LOCK:
          next_st.unlocked = (reg_wdata == UNLOCK_KEY);
        OFS_COMMIT:
          if (st.unlocked)
            next_st.commit = wval;
        OFS_DIRMODE:
          next_st.dm_pin = reg_wdata[2:0];
        default:
          next_st.unlocked = st.unlocked;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_DIR_OUT:  next_st.rdata = {24'h000000, st.dir_out};
        OFS_DIR_PERI: next_st.rdata = {24'h000000, st.dir_peri};
        OFS_PAD_EN:   next_st.rdata = {24'h000000, st.pad_en};
        OFS_PSEL:     next_st.rdata = {24'h000000, st.psel};
        OFS_DATA_OUT: next_st.rdata = {24'h000000, st.data_out};
        OFS_DATA_IN:  next_st.rdata = {24'h000000, lvl};
        OFS_IT_EDGE:  next_st.rdata = {24'h000000, st.it_edge};
        OFS_IT_BOTH:  next_st.rdata = {24'h000000, st.it_both};
        OFS_IT_POL:   next_st.rdata = {24'h000000, st.it_pol};
        OFS_ADC_TRG:  next_st.rdata = {24'h000000, st.adc_en};
        OFS_DMA_TRG:  next_st.rdata = {24'h000000, st.dma_en};
        OFS_INT_EN:   next_st.rdata = {23'h000000, st.int_en};
        OFS_INT_RAW:  next_st.rdata = {23'h000000, st.int_raw};
        OFS_INT_MSK:  next_st.rdata = {23'h000000, masked};
        OFS_LOCK:     next_st.rdata = {31'h00000000, ~st.unlocked};
        OFS_COMMIT:   next_st.rdata = {24'h000000, st.commit};
        OFS_DIRMODE:  next_st.rdata = {27'h0000000, st.dm_pin, dm_code};
        default:      next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st          <= '0;
      st.int_raw  <= RST_SRC;
      st.dir_out  <= RST_BYTE;
      st.dir_peri <= RST_BYTE;
    end
    else
      st <= next_st;
  end

  assign reg_rdata = st.rdata;
  assign adc_trig  = st.adc_trig;
  assign dma_req   = st.dma_req;
  assign irq       = |masked;

  // Irq is combinational from the enables, so dropping every enable must lower it the next cycle
  property p_irq_or;
    @(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == OFS_INT_EN && reg_wdata[8:0] == 9'h000) |=> !irq;
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq stayed up with no enables");

  property p_sticky;
    @(posedge ref_clk) disable iff (srst)
      (st.int_raw[0] && clr_src[0] == 1'b0) |=> st.int_raw[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status bit lost without clear");

  property p_clear;
    @(posedge ref_clk) disable iff (srst)
      (clr_src[3] && !set_src[3]) |=> !st.int_raw[3];
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not take");

  property p_set_wins;
    @(posedge ref_clk) disable iff (srst)
      (clr_src[8] && set_src[8]) |=> st.int_raw[8];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("set lost to clear");

  property p_pad_gate;
    @(posedge ref_clk) disable iff (srst)
      !st.pad_en[2] |-> !pin_oe[2];
  endproperty
  a_pad_gate: assert property (p_pad_gate)
    else $error("unpadded pin drives");

  property p_adc;
    @(posedge ref_clk) disable iff (srst)
      |(hit & st.adc_en) |=> adc_trig;
  endproperty
  a_adc: assert property (p_adc)
    else $error("adc trigger missed");

  property p_dma;
    @(posedge ref_clk) disable iff (srst)
      (hit == 8'h00) |=> !dma_req;
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma request without event");

  property p_lock;
    @(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == OFS_DIR_OUT && !st.unlocked) |=>
        (st.dir_out[0] == $past(st.dir_out[0]));
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked pin reconfigured");

  property p_out_dir;
    @(posedge ref_clk) disable iff (srst)
      (st.pad_en[5] && !st.dir_peri[5]) |-> (pin_oe[5] == st.dir_out[5]);
  endproperty
  a_out_dir: assert property (p_out_dir)
    else $error("pin direction wrong");

  // Reset leaves every pad undriven and the interrupt low
  property p_rst_out;
    @(posedge ref_clk)
      srst |=> (pin_oe == 8'h00 && !irq);
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("pins or irq active after reset");

  // A trigger pin still records its event in the status
  property p_trig_irq;
    @(posedge ref_clk) disable iff (srst)
      |(hit & (st.adc_en | st.dma_en)) |=> ((st.int_raw[7:0] & $past(hit)) == $past(hit));
  endproperty
  a_trig_irq: assert property (p_trig_irq)
    else $error("trigger pin lost its status");

  // Commit takes the byte only while the key is open
  sequence s_commit_wr;
    reg_wr && reg_addr == OFS_COMMIT && st.unlocked;
  endsequence

  property p_commit;
    @(posedge ref_clk) disable iff (srst)
      s_commit_wr |=> (st.commit == $past(reg_wdata[7:0]));
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit byte not taken");

endmodule

// ===== gpp_pkg.sv
/*
  Package for the eight-pin port: register offsets, field layouts, reset values
  and the direction-mode readback encoding.
  Assumes a single 100 MHz clock and a plain register port.
*/
package gpp_pkg;

  localparam int unsigned NPIN = 8;
  localparam int unsigned NSRC = 9;

  // Register byte offsets
  localparam logic [7:0] OFS_DIR_OUT  = 8'h00;
  localparam logic [7:0] OFS_DIR_PERI = 8'h04;
  localparam logic [7:0] OFS_PAD_EN   = 8'h08;
  localparam logic [7:0] OFS_DATA_OUT = 8'h0C;
  localparam logic [7:0] OFS_DATA_IN  = 8'h10;
  localparam logic [7:0] OFS_IT_EDGE  = 8'h14;
  localparam logic [7:0] OFS_IT_BOTH  = 8'h18;
  localparam logic [7:0] OFS_IT_POL   = 8'h1C;
  localparam logic [7:0] OFS_INT_EN   = 8'h20;
  localparam logic [7:0] OFS_INT_RAW  = 8'h24;
  localparam logic [7:0] OFS_INT_MSK  = 8'h28;
  localparam logic [7:0] OFS_INT_CLR  = 8'h2C;
  localparam logic [7:0] OFS_ADC_TRG  = 8'h30;
  localparam logic [7:0] OFS_DMA_TRG  = 8'h34;
  localparam logic [7:0] OFS_LOCK     = 8'h38;
  localparam logic [7:0] OFS_COMMIT   = 8'h3C;
  localparam logic [7:0] OFS_PSEL     = 8'h40;
  localparam logic [7:0] OFS_DIRMODE  = 8'h44;
  localparam logic [7:0] OFS_DMA_ACT  = 8'h48;

  // Key that opens the lock register
  localparam logic [31:0] UNLOCK_KEY  = 32'h4C4F434B;

  // Pins guarded by the lock at reset
  localparam logic [7:0] PROT_PINS    = 8'h0F;

  // Reset values: input, no peripheral, pad off, no triggers
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [8:0] RST_SRC      = 9'h000;

  // Source index of the DMA activity bit
  localparam int unsigned DMA_SRC_BIT = 8;

  // Direction-mode readback encoding
  typedef enum logic [1:0] {
    GPP_DIR_IN   = 2'b00,
    GPP_DIR_OUT  = 2'b01,
    GPP_DIR_PERI = 2'b10
  } gpp_dir_e;

endpackage

// ===== gpp_detect.sv
/*
  Per-pin synchroniser and edge/level event detector for the port.
  Assumes pin levels are sampled on ref_clk; the type bits come from registers.
*/
`timescale 1ns/1ps
module gpp_detect
  import gpp_pkg::*;
(
  input  wire logic ref_clk,   // Port clock
  input  wire logic srst,      // Sync reset, active high
  input  wire logic pin_in,    // Pin level after pad gating
  input  wire logic edge_mode, // 1 edge, 0 level
  input  wire logic both_mode, // Both edges
  input  wire logic polarity,  // 1 rising/high, 0 falling/low
  output logic      level,     // Synchronised level
  output logic      event_hit  // Event this cycle
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } gpp_det_s;

  gpp_det_s st;
  gpp_det_s next_st;

  logic rise;
  logic fall;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  // s1 feeds only s2; detection looks at s2 and s3
  assign rise  = st.s2 & ~st.s3;
  assign fall  = ~st.s2 & st.s3;
  assign level = st.s2;

  always_comb
  begin
    if (edge_mode)
      event_hit = both_mode ? (rise | fall) : (polarity ? rise : fall);
    else
      event_hit = polarity ? st.s2 : ~st.s2;
  end

endmodule

// ===== gpp_pins_model.sv
/*
  Far-side model: pad wires and two peripherals sharing the pins.
  Assumes the bench sets outside levels; a driven pad shows the port value.
*/
`timescale 1ns/1ps
module gpp_pins_model
(
  input  wire logic       ref_clk,   // Port clock
  input  wire logic [7:0] ext_lvl,   // Outside level per pin
  input  wire logic [7:0] oe_a_cfg,  // Peripheral A drive wish
  input  wire logic [7:0] oe_b_cfg,  // Peripheral B drive wish
  input  wire logic [7:0] pin_o,     // Port pad values
  input  wire logic [7:0] pin_oe,    // Port pad enables
  output logic      [7:0] pin_i,     // Resolved pad levels
  output logic      [7:0] peri_a_o,  // Peripheral A value
  output logic      [7:0] peri_a_oe, // Peripheral A enable
  output logic      [7:0] peri_b_o,  // Peripheral B value
  output logic      [7:0] peri_b_oe  // Peripheral B enable
);
  logic [7:0] pat = 8'h5A;
  // Moves every cycle so a stale route cannot match
  always @(posedge ref_clk)
    pat <= pat + 8'h35;
  assign pin_i     = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
  assign peri_a_o  = pat;
  assign peri_b_o  = ~pat;
  assign peri_a_oe = oe_a_cfg;
  assign peri_b_oe = oe_b_cfg;
endmodule

// ===== gpio_port_pin_control_bench.sv
/*
  Self-checking bench for the eight-pin port, random with fixed seed.
  Assumes register reads return the pin vector in bits [7:0].
*/
`timescale 1ns/1ps
module gpio_port_pin_control_bench
  import gpp_pkg::*;
;
  logic        ref_clk, srst, reg_wr, reg_rd, dma_done, adc_trig, dma_req, irq;
  logic [7:0]  reg_addr, pin_o, pin_oe, peri_in, ext_lvl, oe_a_cfg, oe_b_cfg;
  logic [7:0]  pin_i, pa_o, pa_oe, pb_o, pb_oe, exp_out, exp_peri;
  logic [31:0] reg_wdata, reg_rdata, rd_val, rnd;
  logic [6:0]  tbl [5] = '{7'b1001010, 7'b1011000, 7'b1101010, 7'b0001011, 7'b0110111};
  logic [7:0]  ofs [7] = '{OFS_DIR_OUT, OFS_DIR_PERI, OFS_PAD_EN, OFS_INT_EN,
                           OFS_ADC_TRG, OFS_DMA_TRG, 8'h4C};
  int          error_cnt, cmp_count, adc_cnt, dma_cnt, a0, d0;

  gpp_port dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .peri_a_o(pa_o),
    .peri_a_oe(pa_oe), .peri_b_o(pb_o), .peri_b_oe(pb_oe), .peri_in(peri_in),
    .dma_done(dma_done), .adc_trig(adc_trig), .dma_req(dma_req), .irq(irq));
  gpp_pins_model far (.ref_clk(ref_clk), .ext_lvl(ext_lvl), .oe_a_cfg(oe_a_cfg),
    .oe_b_cfg(oe_b_cfg), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i),
    .peri_a_o(pa_o), .peri_a_oe(pa_oe), .peri_b_o(pb_o), .peri_b_oe(pb_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (adc_trig === 1'b1)
      adc_cnt++;
    if (dma_req === 1'b1)
      dma_cnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
    chk(rd_val & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [7:0] upd(logic [7:0] o, logic [7:0] v, logic [7:0] s, bit lk);
    logic [7:0] m;
    m = lk ? (s & ~PROT_PINS) : s;
    return (o & ~m) | (v & m);
  endfunction
  function automatic logic [31:0] code(int p);
    return exp_peri[p] ? GPP_DIR_PERI : (exp_out[p] ? GPP_DIR_OUT : GPP_DIR_IN);
  endfunction
  task automatic end_of_test;
    $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #100us;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    {reg_wr, reg_rd, dma_done, reg_addr, reg_wdata, ext_lvl} = '0;
    {oe_a_cfg, oe_b_cfg, exp_peri} = '0;
    srst = 1'b1;
    rnd  = $urandom(65);
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (ofs[i]) rdchk(ofs[i], 32'hFFFF_FFFF, 32'h0);
    rdchk(OFS_LOCK, 32'h1, 32'h1);
    chk({pin_oe, 7'h0, irq}, 32'h0);
    $display("reset values done");
    wr(OFS_DIR_OUT, 32'hFFFF);
    rnd = $urandom();
    wr(OFS_DIR_OUT, {16'h0, rnd[15:0]});
    exp_out = upd(upd(8'h00, 8'hFF, 8'hFF, 1), rnd[7:0], rnd[15:8], 1);
    rdchk(OFS_DIR_OUT, 32'hFF, {24'h0, exp_out});
    chk(pin_oe, 8'h00);
    wr(OFS_LOCK, UNLOCK_KEY);
    rdchk(OFS_LOCK, 32'h1, 32'h0);
    wr(OFS_COMMIT, 32'h0F0F);
    rnd = $urandom();
    wr(OFS_DIR_OUT, {16'h0, rnd[15:0]});
    exp_out = upd(exp_out, rnd[7:0], rnd[15:8], 0);
    rdchk(OFS_DIR_OUT, 32'hFF, {24'h0, exp_out});
    wr(OFS_PAD_EN, 32'hFFFF);
    wr(OFS_DIR_PERI, 32'h8080);
    wr(OFS_PSEL, 32'h8080);
    exp_peri = 8'h80;
    oe_b_cfg <= rnd[23:16];
    oe_a_cfg <= ~rnd[23:16];
    cyc(1);
    chk(pin_oe, (exp_out & 8'h7F) | (oe_b_cfg & 8'h80));
    chk(pin_o[7], pb_o[7]);
    wr(OFS_DATA_OUT, 32'hFF5A);
    cyc(1);
    chk(pin_o & 8'h7F, 8'h5A);
    for (int p = 0; p < 8; p++)
    begin
      wr(OFS_DIRMODE, p);
      rdchk(OFS_DIRMODE, 32'h3, code(p));
    end
    $display("direction and lock done");
    wr(OFS_DIR_OUT, 32'hFF00);
    wr(OFS_DIR_PERI, 32'hFF00);
    wr(OFS_IT_EDGE, 32'hFFFF);
    wr(OFS_IT_BOTH, 32'hFF00);
    wr(OFS_IT_POL, 32'hFFFF);
    cyc(8);
    wr(OFS_INT_CLR, 32'h1FF);
    wr(OFS_INT_EN, 32'h060);
    wr(OFS_ADC_TRG, 32'hFF20);
    wr(OFS_DMA_TRG, 32'hFF40);
    a0 = adc_cnt;
    d0 = dma_cnt;
    ext_lvl[5] <= 1'b1;
    cyc(8);
    chk(adc_cnt - a0, 1);
    chk(dma_cnt - d0, 0);
    rdchk(OFS_INT_RAW, 32'h60, 32'h20);
    chk(irq, 1'b1);
    wr(OFS_ADC_TRG, 32'hFF00);
    ext_lvl[5] <= 1'b0;
    cyc(8);
    ext_lvl[5] <= 1'b1;
    ext_lvl[6] <= 1'b1;
    cyc(8);
    chk(adc_cnt - a0, 1);
    chk(dma_cnt - d0, 1);
    chk(peri_in, 8'h60);
    rdchk(OFS_DATA_IN, 32'hFF, 32'h60);
    wr(OFS_PAD_EN, 32'h2000);
    cyc(4);
    chk(peri_in, 8'h40);
    wr(OFS_PAD_EN, 32'h2020);
    cyc(4);
    wr(OFS_INT_CLR, 32'h020);
    rdchk(OFS_INT_RAW, 32'h60, 32'h40);
    wr(OFS_INT_EN, 32'h020);
    rdchk(OFS_INT_MSK, 32'h1FF, 32'h0);
    chk(irq, 1'b0);
    $display("triggers done");
    wr(OFS_INT_EN, 32'h010);
    foreach (tbl[i])
    begin
      ext_lvl[4] <= tbl[i][3];
      wr(OFS_IT_EDGE, {24'hFF, {8{tbl[i][6]}}});
      wr(OFS_IT_BOTH, {24'hFF, {8{tbl[i][5]}}});
      wr(OFS_IT_POL, {24'hFF, {8{tbl[i][4]}}});
      cyc(8);
      wr(OFS_INT_CLR, 32'h1FF);
      ext_lvl[4] <= tbl[i][2];
      cyc(8);
      rdchk(OFS_INT_RAW, 32'h10, {27'h0, tbl[i][1], 4'h0});
      chk(irq, tbl[i][1]);
      wr(OFS_INT_CLR, 32'h1FF);
      rdchk(OFS_INT_RAW, 32'h10, {27'h0, tbl[i][0], 4'h0});
    end
    $display("detect modes done");
    wr(OFS_INT_CLR, 32'h1FF);
    wr(OFS_INT_EN, 32'h100);
    dma_done <= 1'b1;
    @(posedge ref_clk);
    dma_done <= 1'b0;
    cyc(4);
    rdchk(OFS_INT_MSK, 32'h1FF, 32'h100);
    chk(irq, 1'b1);
    wr(OFS_INT_EN, 32'h000);
    cyc(1);
    chk(irq, 1'b0);
    rdchk(OFS_INT_RAW, 32'h100, 32'h100);
    @(posedge ref_clk);
    reg_addr  <= OFS_INT_CLR;
    reg_wdata <= 32'h100;
    reg_wr    <= 1'b1;
    dma_done  <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    dma_done  <= 1'b0;
    rdchk(OFS_INT_RAW, 32'h100, 32'h100);
    wr(OFS_INT_CLR, 32'h100);
    rdchk(OFS_INT_RAW, 32'h100, 32'h0);
    $display("dma source done");
    end_of_test();
  end
endmodule
